// [pkg/uabs_defs.svh]
// Offsets, field positions, reset values and timing counts
// Assumes byte addresses on an 8-bit register port, 32-bit words.
`ifndef UABS_DEFS_SVH
`define UABS_DEFS_SVH

`define UABS_ADDR_W 8
`define UABS_OFF_ABORT_REQ 8'h60
`define UABS_OFF_ABORT_DONE 8'h64
`define UABS_OFF_HALT_ARM 8'h68
`define UABS_OFF_RETRY 8'h6c
`define UABS_OFF_FLAGS 8'h70
`define UABS_OFF_ROUTE 8'h74
`define UABS_OFF_PWR 8'h78
`define UABS_OFF_IRQ_STAT 8'h90
`define UABS_OFF_IRQ_MASK 8'h94
`define UABS_OFF_ENG_CTRL 8'h98

`define UABS_RETRY_FS_LSB 16
`define UABS_RETRY_LS_LSB 0
`define UABS_RETRY_W 10
`define UABS_RETRY_RST 32'h0010_0010
`define UABS_ROUTE_RST 4'h0
`define UABS_PWR_RST 6'h00

`define UABS_PWR_DRV_VAL 0
`define UABS_PWR_DRV_EN 1
`define UABS_PWR_SNS_VAL 2
`define UABS_PWR_SNS_EN 3
`define UABS_PWR_OC_VAL 4
`define UABS_PWR_OC_EN 5

`define UABS_ENG_NAK_EN 0
`define UABS_ENG_STALL_EN 1

`define UABS_IRQ_ABORT 0
`define UABS_IRQ_FLAG 1
`define UABS_IRQ_RETRY 2
`define UABS_IRQ_W 3

`define UABS_US_NS 1000
`define UABS_CLK_NS 20
`define UABS_US_CYCLES (`UABS_US_NS / `UABS_CLK_NS)

`endif

// [pkg/uabs_pkg.sv]
// Types shared by the endpoint abort, halt and power control block
// Assumes the protocol engine runs on the same clock as this block.
package uabs_pkg;

    // Per endpoint-direction events from the protocol engine, plus one SETUP received bit
    typedef struct packed {
        logic [31:0] idle;
        logic [31:0] nak_sent;
        logic [31:0] stall_sent;
        logic setup_rcvd;
    } uabs_ev_s;

    // Routing choice, bit 3 down to bit 0
    typedef struct packed {
        logic soft_connect;
        logic route_to_pads;
        logic route_to_external_transceiver;
        logic route_to_internal_transceiver;
    } uabs_route_s;

    // Power signals after override selection
    typedef struct packed {
        logic bus_power_drive;
        logic bus_power_sense;
        logic overcurrent;
    } uabs_pwr_s;

    typedef enum logic [0:0] {RETRY_IDLE, RETRY_WAIT} uabs_retry_e;

endpackage : uabs_pkg

// [hw/uabs_ctrl.sv]
// Endpoint abort, control endpoint halt arm, NAK retry wait, halt/NAK flags,
// routing select and power overrides, with a plain register port.
// Assumes engine events and host_mode_i come from logic on clk_sys_i.
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`include "uabs_defs.svh"

// What this block does
// - An endpoint with its abort requested that goes idle sets its abort-complete bit.
// - Abort completion works only in device mode, paired with the abort request bits.
// - In device mode, while an abort request bit is set, that endpoint is NAKed and its buffers ignored.
// - A SETUP packet received in device mode clears both control endpoint halt arm bits.
// - In host mode a NAK makes the controller wait the programmed microseconds to retry.
// - The full-speed wait is a 10-bit field at bits 25:16 resetting to 0x010.
// - The low-speed wait is a 10-bit field at bits 9:0 resetting to sixteen.
// - In device mode a NAK or halt sets the endpoint flag only if its report enable is on.
// - Endpoint zero takes its enables from engine control, others from their own control.
// - The routing register picks internal, external, pads and soft connect in bits 0-3.
// - A set power override enable replaces the pin signal or the drive request with the register value.
module uabs_ctrl #(
    parameter int US_CYCLES = `UABS_US_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic [`UABS_ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire logic host_mode_i,
    input wire uabs_pkg::uabs_ev_s engine_ev_i,
    input wire logic [15:0] ep_nak_report_en_i,
    input wire logic [15:0] ep_stall_report_en_i,
    input wire logic host_nak_rcvd_i,
    input wire logic host_full_speed_i,
    input wire logic bus_power_drive_req_i,
    input wire logic bus_power_sense_pin_i,
    input wire logic overcurrent_pin_i,
    output logic [31:0] ep_force_nak_o,
    output logic [1:0] halt_arm_o,
    output logic retry_busy_o,
    output logic retry_go_o,
    output uabs_pkg::uabs_route_s route_o,
    output uabs_pkg::uabs_pwr_s pwr_o,
    output logic irq_o
);
    import uabs_pkg::*;

    // Prescaler counts must fit the 16-bit counter; refused at elaboration
    if (US_CYCLES < 1 || US_CYCLES > 65536) begin : g_bad_us_cycles
        $error("US_CYCLES out of range");
    end

    localparam logic [15:0] PRE_LOAD = 16'(US_CYCLES - 1);

    // Register state
    logic [31:0] abort_req_reg, abort_req_next;
    logic [31:0] abort_done_reg, abort_done_next;
    logic [1:0] halt_arm_reg, halt_arm_next;
    logic [9:0] wait_fs_reg, wait_fs_next;
    logic [9:0] wait_ls_reg, wait_ls_next;
    logic [31:0] flags_reg, flags_next;
    logic [3:0] route_reg, route_next;
    logic [5:0] pwr_ovr_reg, pwr_ovr_next;
    logic [1:0] eng_ctrl_reg, eng_ctrl_next;
    logic [`UABS_IRQ_W-1:0] irq_stat_reg, irq_stat_next;
    logic [`UABS_IRQ_W-1:0] irq_mask_reg, irq_mask_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [31:0] force_nak_reg, force_nak_next;

    // Retry timer state
    uabs_retry_e retry_state_reg, retry_state_next;
    logic [9:0] us_left_reg, us_left_next;
    logic [15:0] pre_reg, pre_next;
    logic retry_go_reg, retry_go_next;

    // Pin synchronisers and power outputs
    logic [1:0] pin_meta_reg;
    logic [1:0] pin_sync_reg;
    uabs_pwr_s pwr_reg, pwr_next;

    logic wr_abort_req, wr_abort_done, wr_arm, wr_retry, wr_flags;
    logic wr_route, wr_pwr, wr_stat, wr_mask, wr_eng;
    logic device_mode;
    logic [31:0] nak_en_vec, stall_en_vec;
    logic [31:0] abort_set, flag_set;
    logic [9:0] wait_sel;

    assign device_mode = ~host_mode_i;

    // Write decode, one strobe per register
    assign wr_abort_req = reg_wr_i && (reg_addr_i == `UABS_OFF_ABORT_REQ);
    assign wr_abort_done = reg_wr_i && (reg_addr_i == `UABS_OFF_ABORT_DONE);
    assign wr_arm = reg_wr_i && (reg_addr_i == `UABS_OFF_HALT_ARM);
    assign wr_retry = reg_wr_i && (reg_addr_i == `UABS_OFF_RETRY);
    assign wr_flags = reg_wr_i && (reg_addr_i == `UABS_OFF_FLAGS);
    assign wr_route = reg_wr_i && (reg_addr_i == `UABS_OFF_ROUTE);
    assign wr_pwr = reg_wr_i && (reg_addr_i == `UABS_OFF_PWR);
    assign wr_stat = reg_wr_i && (reg_addr_i == `UABS_OFF_IRQ_STAT);
    assign wr_mask = reg_wr_i && (reg_addr_i == `UABS_OFF_IRQ_MASK);
    assign wr_eng = reg_wr_i && (reg_addr_i == `UABS_OFF_ENG_CTRL);

    // Report enables spread to both directions of each endpoint
    generate
        for (genvar n = 0; n < 16; n++) begin : g_en
            if (n == 0) begin : g_zero
                assign nak_en_vec[1:0] = {2{eng_ctrl_reg[`UABS_ENG_NAK_EN]}};
                assign stall_en_vec[1:0] = {2{eng_ctrl_reg[`UABS_ENG_STALL_EN]}};
            end else begin : g_other
                assign nak_en_vec[2*n+1:2*n] = {2{ep_nak_report_en_i[n]}};
                assign stall_en_vec[2*n+1:2*n] = {2{ep_stall_report_en_i[n]}};
            end
        end
    endgenerate

    // Hardware set terms, device mode only
    assign abort_set = device_mode ? (abort_req_reg & engine_ev_i.idle) : 32'h0000_0000;
    assign flag_set = device_mode ?
        ((engine_ev_i.nak_sent & nak_en_vec) | (engine_ev_i.stall_sent & stall_en_vec)) :
        32'h0000_0000;

    assign wait_sel = host_full_speed_i ? wait_fs_reg : wait_ls_reg;

    // Software registers, flags and interrupt status next values
    always_comb begin
        abort_req_next = wr_abort_req ? reg_wdata_i : abort_req_reg;
        // Set wins over a clear arriving in the same cycle
        abort_done_next = (abort_done_reg & ~(wr_abort_done ? reg_wdata_i : 32'h0000_0000))
            | abort_set;
        flags_next = (flags_reg & ~(wr_flags ? reg_wdata_i : 32'h0000_0000))
            | flag_set;
        halt_arm_next = wr_arm ? reg_wdata_i[1:0] : halt_arm_reg;
        // A SETUP packet outranks a write in the same cycle
        if (device_mode && engine_ev_i.setup_rcvd) begin
            halt_arm_next = 2'h0;
        end
        wait_fs_next = wait_fs_reg;
        wait_ls_next = wait_ls_reg;
        if (wr_retry) begin
            wait_fs_next = reg_wdata_i[`UABS_RETRY_FS_LSB +: `UABS_RETRY_W];
            wait_ls_next = reg_wdata_i[`UABS_RETRY_LS_LSB +: `UABS_RETRY_W];
        end
        route_next = wr_route ? reg_wdata_i[3:0] : route_reg;
        pwr_ovr_next = wr_pwr ? reg_wdata_i[5:0] : pwr_ovr_reg;
        eng_ctrl_next = wr_eng ? reg_wdata_i[1:0] : eng_ctrl_reg;
        irq_mask_next = wr_mask ? reg_wdata_i[`UABS_IRQ_W-1:0] : irq_mask_reg;
        irq_stat_next = irq_stat_reg & ~(wr_stat ? reg_wdata_i[`UABS_IRQ_W-1:0] : 3'h0);
        // Events are fresh bits only, so a held idle does not refire
        if (|(abort_set & ~abort_done_reg)) begin
            irq_stat_next[`UABS_IRQ_ABORT] = 1'b1;
        end
        if (|(flag_set & ~flags_reg)) begin
            irq_stat_next[`UABS_IRQ_FLAG] = 1'b1;
        end
        if (retry_go_next) begin
            irq_stat_next[`UABS_IRQ_RETRY] = 1'b1;
        end
        // Engine sees the forced NAK mask one cycle after the write
        force_nak_next = device_mode ? abort_req_next : 32'h0000_0000;
    end

    // Read mux; data stands only in the cycle after the strobe
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `UABS_OFF_ABORT_REQ: rdata_next = abort_req_reg;
                `UABS_OFF_ABORT_DONE: rdata_next = abort_done_reg;
                `UABS_OFF_HALT_ARM: rdata_next = {30'h0000_0000, halt_arm_reg};
                `UABS_OFF_RETRY: rdata_next = {6'h00, wait_fs_reg, 6'h00, wait_ls_reg};
                `UABS_OFF_FLAGS: rdata_next = flags_reg;
                `UABS_OFF_ROUTE: rdata_next = {28'h000_0000, route_reg};
                `UABS_OFF_PWR: rdata_next = {26'h000_0000, pwr_ovr_reg};
                `UABS_OFF_IRQ_STAT: rdata_next = {29'h0000_0000, irq_stat_reg};
                `UABS_OFF_IRQ_MASK: rdata_next = {29'h0000_0000, irq_mask_reg};
                `UABS_OFF_ENG_CTRL: rdata_next = {30'h0000_0000, eng_ctrl_reg};
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    // Register file state
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            abort_req_reg <= 32'h0000_0000;
            abort_done_reg <= 32'h0000_0000;
            halt_arm_reg <= 2'h0;
            wait_fs_reg <= 10'(`UABS_RETRY_RST >> `UABS_RETRY_FS_LSB);
            wait_ls_reg <= 10'(`UABS_RETRY_RST);
            flags_reg <= 32'h0000_0000;
            route_reg <= `UABS_ROUTE_RST;
            pwr_ovr_reg <= `UABS_PWR_RST;
            eng_ctrl_reg <= 2'h0;
            irq_stat_reg <= 3'h0;
            irq_mask_reg <= 3'h0;
            rdata_reg <= 32'h0000_0000;
            force_nak_reg <= 32'h0000_0000;
        end else begin
            abort_req_reg <= abort_req_next;
            abort_done_reg <= abort_done_next;
            halt_arm_reg <= halt_arm_next;
            wait_fs_reg <= wait_fs_next;
            wait_ls_reg <= wait_ls_next;
            flags_reg <= flags_next;
            route_reg <= route_next;
            pwr_ovr_reg <= pwr_ovr_next;
            eng_ctrl_reg <= eng_ctrl_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            rdata_reg <= rdata_next;
            force_nak_reg <= force_nak_next;
        end
    end

    // Retry wait: microsecond prescaler and microsecond count
    always_comb begin
        retry_state_next = retry_state_reg;
        us_left_next = us_left_reg;
        pre_next = pre_reg;
        retry_go_next = 1'b0;
        case (retry_state_reg)
            RETRY_IDLE: begin
                if (host_mode_i && host_nak_rcvd_i) begin
                    retry_state_next = RETRY_WAIT;
                    us_left_next = wait_sel;
                    pre_next = PRE_LOAD;
                end
            end
            RETRY_WAIT: begin
                if (!host_mode_i) begin
                    // Leaving host mode drops a pending retry
                    retry_state_next = RETRY_IDLE;
                end else if (host_nak_rcvd_i) begin
                    us_left_next = wait_sel;
                    pre_next = PRE_LOAD;
                end else if (us_left_reg == 10'h000) begin
                    retry_state_next = RETRY_IDLE;
                    retry_go_next = 1'b1;
                end else if (pre_reg == 16'h0000) begin
                    pre_next = PRE_LOAD;
                    us_left_next = us_left_reg - 10'h001;
                end else begin
                    pre_next = pre_reg - 16'h0001;
                end
            end
            default: retry_state_next = RETRY_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            retry_state_reg <= RETRY_IDLE;
            us_left_reg <= 10'h000;
            pre_reg <= 16'h0000;
            retry_go_reg <= 1'b0;
        end else begin
            retry_state_reg <= retry_state_next;
            us_left_reg <= us_left_next;
            pre_reg <= pre_next;
            retry_go_reg <= retry_go_next;
        end
    end

    // Power selection: override value replaces the drive request or the synced pin level
    always_comb begin
        pwr_next.bus_power_drive = pwr_ovr_reg[`UABS_PWR_DRV_EN] ?
            pwr_ovr_reg[`UABS_PWR_DRV_VAL] : bus_power_drive_req_i;
        pwr_next.bus_power_sense = pwr_ovr_reg[`UABS_PWR_SNS_EN] ?
            pwr_ovr_reg[`UABS_PWR_SNS_VAL] : pin_sync_reg[0];
        pwr_next.overcurrent = pwr_ovr_reg[`UABS_PWR_OC_EN] ?
            pwr_ovr_reg[`UABS_PWR_OC_VAL] : pin_sync_reg[1];
    end

    // Two-stage synchroniser for the pin inputs, then the output stage
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pin_meta_reg <= 2'h0;
            pin_sync_reg <= 2'h0;
            pwr_reg <= 3'h0;
        end else begin
            pin_meta_reg <= {overcurrent_pin_i, bus_power_sense_pin_i};
            pin_sync_reg <= pin_meta_reg;
            pwr_reg <= pwr_next;
        end
    end

    // Outputs straight from flip-flops, apart from the level interrupt
    assign reg_rdata_o = rdata_reg;
    assign ep_force_nak_o = force_nak_reg;
    assign halt_arm_o = halt_arm_reg;
    assign retry_busy_o = (retry_state_reg == RETRY_WAIT);
    assign retry_go_o = retry_go_reg;
    assign route_o = route_reg;
    assign pwr_o = pwr_reg;
    assign irq_o = |(irq_stat_reg & irq_mask_reg);

endmodule : uabs_ctrl

// [tb/uabs_ctrl_properties.sv]
// Concurrent checks on the ports of the abort, halt, retry and power block
// Assumes it is bound into uabs_ctrl and runs on its single clock.
`timescale 1ns/1ps
`include "uabs_defs.svh"
module uabs_ctrl_properties #(
    parameter int US_CYCLES = 50
) (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic [`UABS_ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic host_mode_i,
    input wire uabs_pkg::uabs_ev_s engine_ev_i,
    input wire logic host_nak_rcvd_i,
    input wire logic [31:0] ep_force_nak_o,
    input wire logic [1:0] halt_arm_o,
    input wire logic retry_busy_o,
    input wire logic retry_go_o,
    input wire uabs_pkg::uabs_route_s route_o,
    input wire uabs_pkg::uabs_pwr_s pwr_o
);
    import uabs_pkg::*;
    // One clock domain, all checks quiet during reset
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!reset_n_i);
    // Register writes that start the multi-step checks
    sequence abort_wr_s;
        reg_wr_i && reg_addr_i == `UABS_OFF_ABORT_REQ && !host_mode_i;
    endsequence
    sequence route_wr_s;
        reg_wr_i && reg_addr_i == `UABS_OFF_ROUTE;
    endsequence
    sequence pwr_wr_s;
        reg_wr_i && reg_addr_i == `UABS_OFF_PWR;
    endsequence
    host_nak_a: assert property (host_mode_i |=> ep_force_nak_o == 32'h0000_0000)
        else $error("endpoint forced to NAK in host mode");
    abort_nak_a: assert property (abort_wr_s ##1 !host_mode_i
        |-> ep_force_nak_o == $past(reg_wdata_i))
        else $error("abort request not shown as forced NAK");
    setup_clear_a: assert property (engine_ev_i.setup_rcvd && !host_mode_i
        |=> halt_arm_o == 2'b00)
        else $error("halt arm survived a SETUP");
    retry_start_a: assert property (host_mode_i && host_nak_rcvd_i |=> retry_busy_o)
        else $error("NAK did not start the retry wait");
    retry_end_a: assert property (retry_go_o |-> !retry_busy_o && $past(retry_busy_o))
        else $error("retry go without a preceding wait");
    route_follow_a: assert property (route_wr_s |=> route_o == $past(reg_wdata_i[3:0]))
        else $error("routing word does not follow write");
    pwr_sense_a: assert property (pwr_wr_s ##0 reg_wdata_i[3]
        |=> ##1 pwr_o.bus_power_sense == $past(reg_wdata_i[2], 2))
        else $error("sense override value not applied");
    pwr_drive_a: assert property (pwr_wr_s ##0 reg_wdata_i[1]
        |=> ##1 pwr_o.bus_power_drive == $past(reg_wdata_i[0], 2))
        else $error("drive override value not applied");
endmodule : uabs_ctrl_properties

bind uabs_ctrl uabs_ctrl_properties #(.US_CYCLES(US_CYCLES)) i_uabs_ctrl_properties (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .host_mode_i(host_mode_i),
    .engine_ev_i(engine_ev_i), .host_nak_rcvd_i(host_nak_rcvd_i),
    .ep_force_nak_o(ep_force_nak_o), .halt_arm_o(halt_arm_o), .retry_busy_o(retry_busy_o),
    .retry_go_o(retry_go_o), .route_o(route_o), .pwr_o(pwr_o)
);

// [tb/uabs_engine_model.sv]
// Protocol engine and bus peer model raising endpoint events on command
// Assumes the bench calls its tasks between edges of clk_sys_i.
`timescale 1ns/1ps
module uabs_engine_model (
    input wire logic clk_sys_i,
    input wire logic [31:0] ep_force_nak_i,
    output uabs_pkg::uabs_ev_s ev_o,
    output logic host_nak_o
);
    import uabs_pkg::*;
    // Quiet lines from time zero
    initial begin
        ev_o = '0;
        host_nak_o = 1'b0;
    end
    // One transaction; an aborted endpoint never halts, it only NAKs
    task automatic access(input int b, input logic halt);
        @(posedge clk_sys_i);
        if (halt && ep_force_nak_i[b] !== 1'b1)
            ev_o.stall_sent[b] <= 1'b1;
        else
            ev_o.nak_sent[b] <= 1'b1;
        @(posedge clk_sys_i);
        ev_o.stall_sent[b] <= 1'b0;
        ev_o.nak_sent[b] <= 1'b0;
    endtask : access
    // Endpoint idle level, held until changed
    task automatic set_idle(input int b, input logic v);
        @(posedge clk_sys_i);
        ev_o.idle[b] <= v;
    endtask : set_idle
    // One-cycle SETUP or host-side NAK pulse
    task automatic pulse(input logic setup);
        @(posedge clk_sys_i);
        ev_o.setup_rcvd <= setup;
        host_nak_o <= !setup;
        @(posedge clk_sys_i);
        ev_o.setup_rcvd <= 1'b0;
        host_nak_o <= 1'b0;
    endtask : pulse
endmodule : uabs_engine_model

// [tb/uabs_ctrl_tb.sv]
// Directed bench for uabs_ctrl over its register port and event inputs
// Assumes US_CYCLES cut to 2 so that retry waits stay short.
`timescale 1ns/1ps
`include "uabs_defs.svh"
module uabs_ctrl_tb;
    import uabs_pkg::*;
    localparam int US = 2;
    logic clk_sys_i, reset_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic host_mode_i = 1'b0, host_full_speed_i = 1'b0, drv_req = 1'b0;
    logic sense_pin = 1'b0, oc_pin = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0000_0000, reg_rdata_o, ep_force_nak_o;
    logic [15:0] nak_en = 16'h0001, stall_en = 16'h0004;
    logic [1:0] halt_arm_o;
    logic retry_busy_o, retry_go_o, irq_o, host_nak;
    uabs_ev_s ev;
    uabs_route_s route_o;
    uabs_pwr_s pwr_o;
    int err_total = 0, check_count = 0, n;

    uabs_ctrl #(.US_CYCLES(US)) i_uabs_ctrl (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .host_mode_i(host_mode_i), .engine_ev_i(ev),
        .ep_nak_report_en_i(nak_en), .ep_stall_report_en_i(stall_en),
        .host_nak_rcvd_i(host_nak), .host_full_speed_i(host_full_speed_i),
        .bus_power_drive_req_i(drv_req), .bus_power_sense_pin_i(sense_pin),
        .overcurrent_pin_i(oc_pin), .ep_force_nak_o(ep_force_nak_o), .halt_arm_o(halt_arm_o),
        .retry_busy_o(retry_busy_o), .retry_go_o(retry_go_o), .route_o(route_o),
        .pwr_o(pwr_o), .irq_o(irq_o)
    );
    uabs_engine_model i_uabs_engine_model (
        .clk_sys_i(clk_sys_i), .ep_force_nak_i(ep_force_nak_o), .ev_o(ev), .host_nak_o(host_nak)
    );

    // 50 MHz clock
    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
            err_total++;
        end
    endtask : chk
    // Single-cycle write; the slave never stalls
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 chk(reg_rdata_o, exp);
    endtask : rd
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    // Hang guard, far beyond the roughly 120 cycles the tests need
    initial begin
        repeat (4000) @(posedge clk_sys_i);
        err_total++;
        report_and_stop();
    end

    initial begin
        repeat (5) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        rd(`UABS_OFF_RETRY, 32'h0010_0010);
        rd(`UABS_OFF_ABORT_DONE, 32'h0000_0000);
        rd(`UABS_OFF_FLAGS, 32'h0000_0000);
        rd(`UABS_OFF_ROUTE, 32'h0000_0000);
        wr(`UABS_OFF_RETRY, 32'hFFFF_FFFF);
        rd(`UABS_OFF_RETRY, 32'h03FF_03FF);
        wr(`UABS_OFF_ROUTE, 32'hFFFF_FFFF);
        rd(`UABS_OFF_ROUTE, 32'h0000_000F);
        chk(route_o, 32'h0000_000F);
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40, 32'h0000_0000);
        $display("test registers done");
        // Abort of EP1 OUT, then an abort attempt in host mode
        wr(`UABS_OFF_IRQ_MASK, 32'h0000_0007);
        wr(`UABS_OFF_ABORT_REQ, 32'h0000_0008);
        #1 chk(ep_force_nak_o, 32'h0000_0008);
        i_uabs_engine_model.set_idle(3, 1'b1);
        rd(`UABS_OFF_ABORT_DONE, 32'h0000_0008);
        rd(`UABS_OFF_ABORT_DONE, 32'h0000_0008);
        chk(irq_o, 32'h0000_0001);
        wr(`UABS_OFF_IRQ_MASK, 32'h0000_0000);
        #1 chk(irq_o, 32'h0000_0000);
        wr(`UABS_OFF_ABORT_REQ, 32'h0000_0000);
        wr(`UABS_OFF_ABORT_DONE, 32'h0000_0008);
        rd(`UABS_OFF_ABORT_DONE, 32'h0000_0000);
        host_mode_i <= 1'b1;
        wr(`UABS_OFF_ABORT_REQ, 32'h0000_0008);
        rd(`UABS_OFF_ABORT_DONE, 32'h0000_0000);
        chk(ep_force_nak_o, 32'h0000_0000);
        wr(`UABS_OFF_ABORT_REQ, 32'h0000_0000);
        host_mode_i <= 1'b0;
        i_uabs_engine_model.set_idle(3, 1'b0);
        wr(`UABS_OFF_IRQ_MASK, 32'h0000_0007);
        wr(`UABS_OFF_IRQ_STAT, 32'h0000_0007);
        #1 chk(irq_o, 32'h0000_0000);
        $display("test abort done");
        // EP0 enables come from engine control only
        i_uabs_engine_model.access(0, 1'b0);
        rd(`UABS_OFF_FLAGS, 32'h0000_0000);
        wr(`UABS_OFF_ENG_CTRL, 32'h0000_0001);
        i_uabs_engine_model.access(1, 1'b0);
        i_uabs_engine_model.access(4, 1'b1);
        i_uabs_engine_model.access(5, 1'b1);
        i_uabs_engine_model.access(6, 1'b0);
        rd(`UABS_OFF_FLAGS, 32'h0000_0032);
        wr(`UABS_OFF_FLAGS, 32'h0000_0002);
        rd(`UABS_OFF_FLAGS, 32'h0000_0030);
        host_mode_i <= 1'b1;
        i_uabs_engine_model.access(1, 1'b0);
        rd(`UABS_OFF_FLAGS, 32'h0000_0030);
        host_mode_i <= 1'b0;
        $display("test flags done");
        wr(`UABS_OFF_HALT_ARM, 32'h0000_0003);
        rd(`UABS_OFF_HALT_ARM, 32'h0000_0003);
        i_uabs_engine_model.pulse(1'b1);
        rd(`UABS_OFF_HALT_ARM, 32'h0000_0000);
        chk(halt_arm_o, 32'h0000_0000);
        $display("test setup done");
        // Full speed wait 3 us, low speed wait 0 us
        host_mode_i <= 1'b1;
        wr(`UABS_OFF_RETRY, 32'h0003_0000);
        for (int i = 0; i < 2; i++) begin
            host_full_speed_i <= (i == 0);
            i_uabs_engine_model.pulse(1'b0);
            n = 1;
            #1 chk(retry_busy_o, 32'h0000_0001);
            while (retry_go_o !== 1'b1 && n < 200) begin
                @(posedge clk_sys_i);
                #1 n++;
            end
            chk(n, (i == 0) ? 3 * US + 2 : 2);
            chk(retry_busy_o, 32'h0000_0000);
        end
        host_mode_i <= 1'b0;
        $display("test retry done");
        // Pins high, then overrides: enables with zero values first, values set after
        drv_req <= 1'b1;
        sense_pin <= 1'b1;
        oc_pin <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        #1 chk(pwr_o, 32'h0000_0007);
        wr(`UABS_OFF_PWR, 32'h0000_0000);
        wr(`UABS_OFF_PWR, 32'h0000_002A);
        @(posedge clk_sys_i);
        #1 chk(pwr_o, 32'h0000_0000);
        drv_req <= 1'b0;
        sense_pin <= 1'b0;
        oc_pin <= 1'b0;
        wr(`UABS_OFF_PWR, 32'h0000_003F);
        repeat (4) @(posedge clk_sys_i);
        #1 chk(pwr_o, 32'h0000_0007);
        rd(`UABS_OFF_PWR, 32'h0000_003F);
        $display("test power done");
        report_and_stop();
    end
endmodule : uabs_ctrl_tb
